// ==== rtl/ccg_params.svh ====
// constants and timing counts for the cpu clock generator
// Summary of operation
// - the three clock mode strap levels are caught on the first pll clock edge after reset release and hold the clock mode until the next reset.
// - strap code 111 is x4, 110 x3, 101 x2, 100 x5, 011 direct, 010 x1.5, 001 divide by 2 and 000 x2.5.
// - code 001 divides the input by two, each cpu half period lasting one input period.
// - code 011 turns the pll path off and the cpu clock follows the input, duty cycle included.
// - in direct drive two consecutive cpu half periods always add up to one input period.
// - both cpu clock edges trigger internal work and the time between edges is the basic unit.
// - the oscillator supervisor only watches the input in direct and prescaled modes.
// - the supervisor is on after every reset and is switched off by bit 4 of the system config register.
// - while the supervisor is on, the pll free-runs and each pll cycle counts the supervisor counter up.
// - every transition on the crystal input clears the supervisor counter.
// - sixteen pll cycles with no input transition overflow the counter, which means the input clock failed.
// - on overflow the cpu clock moves to the free-running pll and the fail interrupt request is flagged.
// - once on the pll clock the block stays there until a hardware reset.
// - with the supervisor off in direct or divide by 2 mode and before any failover, the cpu clock comes from the input and the pll is powered down.
`ifndef CCG_PARAMS_SVH
`define CCG_PARAMS_SVH
`define CCG_STRAP_RESET 3'h7
`define CCG_CODE_X4 3'h7
`define CCG_CODE_X3 3'h6
`define CCG_CODE_X2 3'h5
`define CCG_CODE_X5 3'h4
`define CCG_CODE_DIRECT 3'h3
`define CCG_CODE_X1P5 3'h2
`define CCG_CODE_DIV2 3'h1
`define CCG_CODE_X2P5 3'h0
`define CCG_SYSCFG_SUPV_DIS_BIT 4
`define CCG_SUPV_LIMIT 16
`endif

// ==== rtl/ccg_pkg.sv ====
// types for the cpu clock generator
package ccg_pkg;
  typedef enum logic [2:0] {
    CCG_MODE_X2P5, CCG_MODE_DIV2, CCG_MODE_X1P5, CCG_MODE_DIRECT,
    CCG_MODE_X5, CCG_MODE_X2, CCG_MODE_X3, CCG_MODE_X4
  } ccg_mode_e;
  typedef enum {CCG_SRC_INPUT, CCG_SRC_SWITCH, CCG_SRC_PLL} ccg_src_e;
endpackage

// ==== rtl/ccg_supv_if.sv ====
// link between the clock selector and the oscillator supervisor
`timescale 1ns/10ps
interface ccg_supv_if;
  logic enable;
  logic input_edge;
  logic overflow;
  modport ctrl (output enable, output input_edge, input overflow);
  modport supv (input enable, input input_edge, output overflow);
endinterface

// ==== rtl/ccg_supervisor.sv ====
// oscillator supervisor counter
`timescale 1ns/10ps
`include "ccg_params.svh"
module ccg_supervisor #(
  parameter int LIMIT = `CCG_SUPV_LIMIT
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // link to selector
  ccg_supv_if.supv link
);
  localparam int CW = $clog2(LIMIT + 1);
  initial begin
    if (LIMIT < 2) $error("ccg_supervisor: LIMIT too small");
  end
  logic [CW-1:0] count_reg;
  logic [CW-1:0] count_next;
  logic ovf_reg;
  logic ovf_next;
  always_comb begin
    count_next = count_reg;
    ovf_next = ovf_reg;
    if (!link.enable) begin
      count_next = '0;
    end else if (link.input_edge) begin
      count_next = '0;
    end else if (count_reg == CW'(LIMIT - 1)) begin
      count_next = '0;
      ovf_next = 1'b1;
    end else begin
      count_next = count_reg + CW'(1);
    end
  end
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      count_reg <= '0;
      ovf_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      ovf_reg <= ovf_next;
    end
  end
  assign link.overflow = ovf_reg;
endmodule // ccg_supervisor

// ==== rtl/ccg_clock_gen.sv ====
// cpu clock selection, prescaler and oscillator supervision
`timescale 1ns/10ps
`include "ccg_params.svh"
module ccg_clock_gen #(
  parameter int SUPV_LIMIT = `CCG_SUPV_LIMIT
) (
  // clock and reset; ref_clk models the free-running pll clock
  input wire logic ref_clk,
  input wire logic resetn,
  // external clock and straps
  input wire logic crystal_input_pin,
  input wire logic [2:0] clock_mode_strap_pins,
  // system configuration
  input wire logic [15:0] system_config_register,
  // outputs
  output logic cpu_clk,
  output logic cpu_edge,
  output logic [2:0] clock_mode,
  output logic pll_mult_mode,
  output logic pll_power,
  output logic on_pll_clock,
  output logic osc_fail_interrupt_request
);
  initial begin
    if (SUPV_LIMIT < 2) $error("ccg_clock_gen: SUPV_LIMIT too small");
  end

  // ----------------------------------------
  // strap capture
  // ----------------------------------------
  // straps are sampled on the first edge after reset release, frozen from then on
  logic armed_reg;
  logic armed_next;
  logic [2:0] mode_reg;
  logic [2:0] mode_next;
  always_comb begin
    armed_next = 1'b1;
    mode_next = armed_reg ? mode_reg : clock_mode_strap_pins;
  end
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      armed_reg <= 1'b0;
      mode_reg <= `CCG_STRAP_RESET;
    end else begin
      armed_reg <= armed_next;
      mode_reg <= mode_next;
    end
  end

  // ----------------------------------------
  // mode decode
  // ----------------------------------------
  logic is_direct;
  logic is_div2;
  logic supv_dis;
  always_comb begin
    is_direct = 1'b0;
    is_div2 = 1'b0;
    if (mode_reg == `CCG_CODE_DIRECT) begin
      is_direct = 1'b1;
    end else if (mode_reg == `CCG_CODE_DIV2) begin
      is_div2 = 1'b1;
    end
  end
  assign supv_dis = system_config_register[`CCG_SYSCFG_SUPV_DIS_BIT];
  // multiplying codes (x1.5..x5) are left to the analog pll, flagged here
  assign pll_mult_mode = armed_reg && !is_direct && !is_div2;

  // ----------------------------------------
  // input edge detect
  // ----------------------------------------
  logic xin_reg;
  logic xin_next;
  assign xin_next = crystal_input_pin;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      xin_reg <= 1'b0;
    end else begin
      xin_reg <= xin_next;
    end
  end

  ccg_supv_if supv_link ();
  assign supv_link.enable = armed_reg && (is_direct || is_div2) && !supv_dis;
  assign supv_link.input_edge = xin_reg ^ crystal_input_pin;

  ccg_supervisor #(
    .LIMIT(SUPV_LIMIT)
  ) u_supervisor (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .link(supv_link.supv)
  );

  // ----------------------------------------
  // source selection
  // ----------------------------------------
  ccg_pkg::ccg_src_e src_reg;
  ccg_pkg::ccg_src_e src_next;
  logic irq_reg;
  logic irq_next;
  logic div_reg;
  logic div_next;
  logic pll_ph_reg;
  logic pll_ph_next;
  logic clk_reg;
  logic clk_next;
  always_comb begin
    src_next = src_reg;
    irq_next = irq_reg;
    div_next = div_reg;
    pll_ph_next = ~pll_ph_reg;
    clk_next = clk_reg;
    if (supv_link.input_edge && crystal_input_pin) begin
      div_next = ~div_reg;
    end
    case (src_reg)
      ccg_pkg::CCG_SRC_INPUT: begin
        clk_next = is_div2 ? div_next : crystal_input_pin;
        if (supv_link.overflow) begin
          src_next = ccg_pkg::CCG_SRC_SWITCH;
          irq_next = 1'b1;
        end
      end
      ccg_pkg::CCG_SRC_SWITCH: begin
        // hold the current level until the pll phase matches, no runt pulse
        if (pll_ph_next == clk_reg) begin
          src_next = ccg_pkg::CCG_SRC_PLL;
        end
      end
      ccg_pkg::CCG_SRC_PLL: begin
        clk_next = pll_ph_next;
      end
      default: begin
        src_next = ccg_pkg::CCG_SRC_INPUT;
      end
    endcase
  end
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      src_reg <= ccg_pkg::CCG_SRC_INPUT;
      irq_reg <= 1'b0;
      div_reg <= 1'b0;
      pll_ph_reg <= 1'b0;
      clk_reg <= 1'b0;
    end else begin
      src_reg <= src_next;
      irq_reg <= irq_next;
      div_reg <= div_next;
      pll_ph_reg <= pll_ph_next;
      clk_reg <= clk_next;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  logic clk_q_reg;
  logic clk_q_next;
  assign clk_q_next = clk_reg;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      clk_q_reg <= 1'b0;
    end else begin
      clk_q_reg <= clk_q_next;
    end
  end
  assign cpu_clk = clk_reg;
  assign cpu_edge = clk_reg ^ clk_q_reg;
  assign clock_mode = mode_reg;
  // pll runs when supervising, when multiplying, or once failed over
  assign pll_power = supv_link.enable || pll_mult_mode || (src_reg != ccg_pkg::CCG_SRC_INPUT);
  assign on_pll_clock = (src_reg == ccg_pkg::CCG_SRC_PLL);
  assign osc_fail_interrupt_request = irq_reg;
endmodule // ccg_clock_gen

// ==== dv/ccg_props.sv ====
// port assertions for the cpu clock generator
`timescale 1ns/10ps
module ccg_props #(
  parameter int SUPV_LIMIT = 16
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // watched ports
  input wire logic crystal_input_pin,
  input wire logic [15:0] system_config_register,
  input wire logic cpu_clk,
  input wire logic [2:0] clock_mode,
  input wire logic pll_power,
  input wire logic on_pll_clock,
  input wire logic osc_fail_interrupt_request
);
  // ----------------------------------------
  // quiet time of the input, in pll cycles
  // ----------------------------------------
  logic [7:0] quiet_reg;
  logic [7:0] quiet_next;
  logic last_reg;
  logic sup_on;
  logic irq;
  assign irq = osc_fail_interrupt_request;
  assign sup_on = (clock_mode == 3'h3 || clock_mode == 3'h1) && !system_config_register[4];
  always_comb quiet_next = (crystal_input_pin != last_reg || !sup_on) ? 8'h00 : quiet_reg + 8'h01;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      quiet_reg <= 8'h00;
      last_reg <= 1'b0;
    end else begin
      quiet_reg <= quiet_next;
      last_reg <= crystal_input_pin;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  AST_MODE_HOLD: assert property ($past(resetn, 2) |-> $stable(clock_mode)) else $error("mode moved");
  AST_MULT_QUIET: assert property (!(clock_mode inside {3'h3, 3'h1}) |-> !irq) else $error("irq in pll mode");
  AST_IRQ_STICKY: assert property (irq |=> irq) else $error("irq dropped");
  AST_PLL_STICKY: assert property (on_pll_clock |=> on_pll_clock) else $error("left pll");
  AST_IRQ_TO_PLL: assert property ($rose(irq) |-> ##[0:3] on_pll_clock) else $error("no pll switch");
  AST_NO_EARLY: assert property ($rose(irq) |-> quiet_reg >= SUPV_LIMIT) else $error("early fail");
  AST_LATE_FAIL: assert property (quiet_reg == SUPV_LIMIT + 4 |-> irq) else $error("missed fail");
  AST_PWR_OFF: assert property (system_config_register[4] && !on_pll_clock |-> !pll_power) else $error("pll on");
  AST_DIRECT: assert property (clock_mode == 3'h3 && $past(clock_mode) == 3'h3 && !irq
    |-> cpu_clk == $past(crystal_input_pin)) else $error("direct mismatch");
  AST_DIV2: assert property (clock_mode == 3'h1 && $past(clock_mode) == 3'h1 && !irq && $rose(crystal_input_pin)
    |-> ##[1:2] $changed(cpu_clk)) else $error("no div toggle");
  AST_PLL_RUN: assert property (on_pll_clock && $past(on_pll_clock, 3) |-> cpu_clk != $past(cpu_clk))
    else $error("pll clock stuck");
  cover property ($rose(irq));
  cover property (clock_mode == 3'h1 && $changed(cpu_clk));
  cover property (system_config_register[4] && clock_mode == 3'h3);
endmodule // ccg_props
bind ccg_clock_gen ccg_props #(.SUPV_LIMIT(SUPV_LIMIT)) i_props (.ref_clk(ref_clk), .resetn(resetn),
  .crystal_input_pin(crystal_input_pin), .system_config_register(system_config_register), .cpu_clk(cpu_clk),
  .clock_mode(clock_mode), .pll_power(pll_power), .on_pll_clock(on_pll_clock),
  .osc_fail_interrupt_request(osc_fail_interrupt_request));

// ==== dv/ccg_osc_model.sv ====
// crystal oscillator model driving the clock input
`timescale 1ns/10ps
module ccg_osc_model (
  // control
  input wire logic run,
  input wire logic [15:0] high_ns,
  input wire logic [15:0] low_ns,
  // clock out
  output logic crystal_input_pin
);
  // a dead crystal finishes its cycle and holds low; odd start offset keeps edges off ref_clk
  initial begin
    crystal_input_pin = 1'b0;
    forever begin
      wait (run);
      #37;
      while (run) begin
        crystal_input_pin = 1'b1;
        #(high_ns);
        crystal_input_pin = 1'b0;
        #(low_ns);
      end
    end
  end
endmodule // ccg_osc_model

// ==== dv/test_ccg_clock_gen.sv ====
// self-checking bench for the cpu clock generator
`timescale 1ns/10ps
module test_ccg_clock_gen;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic [2:0] straps = 3'h7;
  logic [15:0] cfg = 16'h0000;
  logic run = 1'b0;
  logic [15:0] hi_ns = 16'h012c;
  logic [15:0] lo_ns = 16'h01f4;
  logic xtal, cpu_clk, mult, pwr, on_pll, irq;
  logic [2:0] mode;
  int mismatches = 0;
  int cmp_count = 0;
  ccg_osc_model i_osc (.run(run), .high_ns(hi_ns), .low_ns(lo_ns), .crystal_input_pin(xtal));
  ccg_clock_gen i_dut (.ref_clk(ref_clk), .resetn(resetn), .crystal_input_pin(xtal),
    .clock_mode_strap_pins(straps), .system_config_register(cfg), .cpu_clk(cpu_clk), .cpu_edge(),
    .clock_mode(mode), .pll_mult_mode(mult), .pll_power(pwr), .on_pll_clock(on_pll),
    .osc_fail_interrupt_request(irq));
  initial begin
    forever #50 ref_clk = ~ref_clk;
  end
  task automatic close_out();
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %0h seen %0h", name, exp, got);
    end
  endtask
  task automatic start(input logic [2:0] code, input logic dis);
    @(posedge ref_clk);
    resetn <= 1'b0;
    run <= 1'b0;
    straps <= code;
    cfg <= dis ? 16'h0010 : 16'h0000;
    repeat (8) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    straps <= ~code;
    run <= 1'b1;
    @(negedge ref_clk);
  endtask
  task automatic halves(input logic [7:0] hi, input logic [7:0] lo);
    logic [7:0] h;
    logic [7:0] l;
    h = 8'h00;
    l = 8'h00;
    while (cpu_clk !== 1'b0) @(negedge ref_clk);
    while (cpu_clk !== 1'b1) @(negedge ref_clk);
    while (cpu_clk === 1'b1) begin h++; @(negedge ref_clk); end
    while (cpu_clk === 1'b0) begin l++; @(negedge ref_clk); end
    chk("high cycles", hi, h);
    chk("low cycles", lo, l);
  endtask
  task automatic t_modes();
    for (int c = 0; c < 8; c++) begin
      start(c[2:0], 1'b0);
      chk("clock_mode", c[2:0], mode);
      chk("pll_mult_mode", {7'h00, c != 3 && c != 1}, mult);
    end
  endtask
  task automatic t_quiet(input logic [2:0] code, input logic dis);
    start(code, dis);
    @(posedge ref_clk);
    run <= 1'b0;
    repeat (40) @(negedge ref_clk);
    chk("irq", 8'h00, irq);
    chk("pll_power", {7'h00, !dis}, pwr);
  endtask
  task automatic t_clocks();
    start(3'h3, 1'b0);
    halves(8'h03, 8'h05);
    hi_ns <= 16'h0190;
    lo_ns <= 16'h0190;
    start(3'h1, 1'b0);
    halves(8'h08, 8'h08);
  endtask
  task automatic t_fail();
    logic [7:0] n;
    logic prev;
    hi_ns <= 16'h012c;
    lo_ns <= 16'h01f4;
    start(3'h3, 1'b0);
    repeat (20) @(negedge ref_clk);
    chk("irq running", 8'h00, irq);
    @(posedge ref_clk);
    run <= 1'b0;
    n = 8'h00;
    prev = xtal;
    while (irq !== 1'b1 && n < 8'h30) begin
      @(negedge ref_clk);
      n = (xtal !== prev) ? 8'h00 : n + 8'h01;
      prev = xtal;
    end
    chk("fail delay", 8'h11, n);
    @(posedge ref_clk);
    run <= 1'b1;
    repeat (30) @(negedge ref_clk);
    chk("on_pll_clock", 8'h01, on_pll);
    prev = cpu_clk;
    @(negedge ref_clk);
    chk("pll toggle", {7'h00, ~prev}, cpu_clk);
    start(3'h3, 1'b0);
    chk("pll after reset", 8'h00, on_pll);
    chk("irq after reset", 8'h00, irq);
  endtask
  initial begin
    #1_000_000;
    mismatches++;
    close_out();
  end
  initial begin
    t_modes();
    t_clocks();
    t_quiet(3'h7, 1'b0);
    t_quiet(3'h3, 1'b1);
    t_fail();
    close_out();
  end
endmodule // test_ccg_clock_gen
